/* src/dram_ctl_pkg.sv */
// Constants and timing counts for the asynchronous DRAM controller.
// Assumes a 100 MHz controller clock; all times are converted to cycles here.
//
// How it works
// - Row on row-strobe fall, column on column-strobe fall
// - Cycle ends both high; honour row precharge
// - Never abort before minimum strobe pulse widths
// - Write-select high throughout gives a read
// - Column strobe within row-to-column delay maximum
// - Output gate low across access window
// - Write data valid by later falling edge
// - Write-select before column strobe: early write (here both fall on one clock edge)
// - Write-select after column strobe: read-modify-write
// - Refresh every row within each 8 ms
// - Row-only refresh visits all 512 rows
// - Column strobe before row strobe uses counter
// - Hidden refresh: column low, row strobe cycled
// - Counter test: column toggled while row low
// - Page mode: row low, column strobe cycled
// - Both strobes high during power-up
// - Wait 200 us, then eight row cycles
// - 18-bit address split into row, column halves
package dram_ctl_pkg;

	localparam int CLK_PERIOD_PS = 10000;

	// Documented times in picoseconds (power-up in us, refresh in ms), then cycles (mins round up)
	localparam int ROW_PRECHARGE_PS   = 80000;
	localparam int ROW_PULSE_PS       = 100000;
	localparam int ROW_TO_COLUMN_PS   = 25000;
	localparam int COLUMN_PULSE_PS    = 25000;
	localparam int ACCESS_ROW_PS      = 100000;
	localparam int REFRESH_COL_SETUP_PS = 10000;
	localparam int REFRESH_COL_HOLD_PS  = 30000;
	localparam int COLUMN_PRECHARGE_PS  = 15000;
	localparam int OUTPUT_GATE_OFF_PS   = 25000;
	localparam int POWERUP_WAIT_US    = 200;
	localparam int REFRESH_PERIOD_MS  = 8;

	localparam int RP_CYC   = (ROW_PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RAS_CYC  = (ROW_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RCD_CYC  = (ROW_TO_COLUMN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CAS_CYC  = (COLUMN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RAC_CYC  = (ACCESS_ROW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CSR_CYC  = (REFRESH_COL_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CHR_CYC  = (REFRESH_COL_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CPN_CYC  = (COLUMN_PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OEZ_CYC  = (OUTPUT_GATE_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWERUP_CYC = POWERUP_WAIT_US * 100;
	// 512 refreshes spread over the period: interval rounded down
	localparam int REFRESH_ROWS = 512;
	localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_MS * 100000 / REFRESH_ROWS;

	localparam int INIT_CYCLES = 8;
	localparam int ROW_BITS    = 9;
	localparam int ADDR_BITS   = 18;
	localparam int DATA_BITS   = 4;

	typedef enum logic [3:0] {
		ST_POWERUP  = 4'b0000,
		ST_IDLE     = 4'b0001,
		ST_ROW      = 4'b0011,
		ST_COL      = 4'b0010,
		ST_HOLD     = 4'b0110,
		ST_PRECHG   = 4'b0111,
		ST_CBR_SET  = 4'b0101,
		ST_CBR_ROW  = 4'b0100,
		ST_PAGE_PRE = 4'b1100
	} state_e;

endpackage

/* src/pin_sync.sv */
// Two-flop synchroniser for the shared data pins.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* src/refresh_timer.sv */
// Refresh request timer: one request per row interval, sticky until taken.
// Assumes the controller pulses take_i when it starts a refresh.
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
	parameter int INTERVAL = dram_ctl_pkg::REFRESH_INTERVAL_CYC
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic run_i,
	input  wire logic take_i,
	output logic      req_o
);
	logic [15:0] cnt_q;

	initial begin
		if (INTERVAL < 2 || INTERVAL > 65535) $error("refresh_timer: bad interval");
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= '0;
			req_o <= 1'b0;
		end else if (run_i) begin
			// New tick wins over a take in the same cycle
			if (cnt_q == 16'(INTERVAL - 1)) begin
				cnt_q <= '0;
				req_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
				if (take_i) req_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* src/dram_ctl.sv */
// Controller for a 256K x 4 asynchronous DRAM, driving its pins directly.
// Assumes ref_clk at 100 MHz and a DRAM meeting the documented timing.
`timescale 1ns/1ps
`default_nettype none
module dram_ctl #(
	parameter int POWERUP_CYCLES = dram_ctl_pkg::POWERUP_CYC,
	parameter int REFRESH_INTERVAL = dram_ctl_pkg::REFRESH_INTERVAL_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// User request side
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_rmw,
	input  wire logic        req_page,
	input  wire logic        req_cbr_test,
	input  wire logic [17:0] req_addr,
	input  wire logic [3:0]  req_wdata,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [3:0]       rsp_rdata,
	output logic             init_done,
	// DRAM pins
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	output logic             write_select_n,
	output logic             output_gate_n,
	output logic [8:0]       multiplexed_address,
	input  wire logic [3:0]  data_in,
	output logic [3:0]       data_out,
	output logic             data_oe
);
	initial begin
		if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 65535) $error("dram_ctl: bad power-up count");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dram_ctl_pkg::state_e st;
		logic [15:0] cnt;
		logic [3:0]  inits;
		logic        write;
		logic        rmw;
		logic        page;
		logic        test;
		logic        refresh;
		logic [8:0]  row;
		logic [8:0]  col;
		logic [3:0]  wdata;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic        oe_n;
		logic [8:0]  addr;
		logic [3:0]  dout;
		logic        doe;
		logic        ready;
		logic        rvalid;
		logic [3:0]  rdata;
		logic        done;
		logic        take;
	} ctl_s;

	ctl_s s_q;
	ctl_s s_d;
	logic [3:0] din_sync;
	logic       ref_req;

	pin_sync #(.WIDTH(4)) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (data_in),
		.sync_out (din_sync)
	);

	refresh_timer #(.INTERVAL(REFRESH_INTERVAL)) u_ref (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run_i   (s_q.done),
		.take_i  (s_q.take),
		.req_o   (ref_req)
	);

	function automatic logic expired(input logic [15:0] c, input int n);
		return c >= 16'(n - 1);
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.take   = 1'b0;
		s_d.cnt    = s_q.cnt + 16'h0001;
		case (s_q.st)
			dram_ctl_pkg::ST_POWERUP: begin
				// Strobes held high through power-up pause
				if (expired(s_q.cnt, POWERUP_CYCLES)) begin
					s_d.st      = dram_ctl_pkg::ST_PRECHG;
					s_d.cnt     = '0;
					s_d.refresh = 1'b1;
					s_d.inits   = 4'h0;
				end
			end
			dram_ctl_pkg::ST_IDLE: begin
				s_d.cnt = '0;
				if (ref_req || !s_q.done) begin
					// Column-before-row refresh, counter supplies the row
					s_d.refresh = 1'b1;
					s_d.take    = 1'b1;
					s_d.ready   = 1'b0;
					s_d.cas_n   = 1'b0;
					s_d.st      = dram_ctl_pkg::ST_CBR_SET;
				end else if (req_valid) begin
					// Split word address into row and column halves
					s_d.row     = req_addr[17:9];
					s_d.col     = req_addr[8:0];
					s_d.write   = req_write;
					s_d.rmw     = req_rmw;
					s_d.page    = req_page;
					s_d.test    = req_cbr_test;
					s_d.wdata   = req_wdata;
					s_d.ready   = 1'b0;
					s_d.refresh = 1'b0;
					if (req_cbr_test) begin
						s_d.cas_n = 1'b0;
						s_d.st    = dram_ctl_pkg::ST_CBR_SET;
					end else begin
						s_d.addr = req_addr[17:9];
						s_d.st   = dram_ctl_pkg::ST_ROW;
					end
				end
			end
			dram_ctl_pkg::ST_CBR_SET: begin
				// One spare cycle of set-up covers strobe skew at the pins
				if (expired(s_q.cnt, dram_ctl_pkg::CSR_CYC + 1)) begin
					s_d.ras_n = 1'b0;
					s_d.cnt   = '0;
					s_d.st    = dram_ctl_pkg::ST_CBR_ROW;
				end
			end
			dram_ctl_pkg::ST_CBR_ROW: begin
				if (s_q.test && expired(s_q.cnt, dram_ctl_pkg::CHR_CYC)) begin
					// Counter test: column strobe up then down with row held
					if (!s_q.cas_n) begin
						s_d.cas_n = 1'b1;
						s_d.cnt   = '0;
						s_d.addr  = s_q.col;
					end else if (expired(s_q.cnt, dram_ctl_pkg::CPN_CYC + 4)) begin
						s_d.cnt   = '0;
						s_d.st    = dram_ctl_pkg::ST_COL;
						s_d.cas_n = 1'b0;
						s_d.we_n  = !s_q.write;
						s_d.oe_n  = s_q.write;
						s_d.dout  = s_q.wdata;
						s_d.doe   = s_q.write;
					end
				end else if (!s_q.test && expired(s_q.cnt, dram_ctl_pkg::RAS_CYC)) begin
					// Row strobe held its full minimum
					s_d.ras_n = 1'b1;
					s_d.cas_n = 1'b1;
					s_d.cnt   = '0;
					s_d.st    = dram_ctl_pkg::ST_PRECHG;
				end
			end
			dram_ctl_pkg::ST_ROW: begin
				// Row latched with column strobe high
				if (s_q.ras_n) begin
					s_d.ras_n = 1'b0;
					s_d.cnt   = '0;
				end else if (expired(s_q.cnt, dram_ctl_pkg::RCD_CYC)) begin
					// Column strobe early enough to count access from row
					s_d.addr = s_q.col;
					s_d.st   = dram_ctl_pkg::ST_PAGE_PRE;
					s_d.cnt  = '0;
				end
			end
			dram_ctl_pkg::ST_PAGE_PRE: begin
				// Column address set up one cycle before its strobe falls
				s_d.cas_n = 1'b0;
				s_d.cnt   = '0;
				s_d.st    = dram_ctl_pkg::ST_COL;
				// Early write: write-select down on the same edge as the column strobe
				s_d.we_n  = !(s_q.write && !s_q.rmw);
				s_d.dout  = s_q.wdata;
				s_d.doe   = s_q.write && !s_q.rmw;
				// Gate low only when data is wanted
				s_d.oe_n  = s_q.write && !s_q.rmw;
			end
			dram_ctl_pkg::ST_COL: begin
				if (expired(s_q.cnt, dram_ctl_pkg::RAC_CYC)) begin
					if (!s_q.write || s_q.rmw) begin
						// Data sampled after access plus synchroniser
						s_d.rdata  = din_sync;
						s_d.rvalid = 1'b1;
					end
					if (s_q.rmw) begin
						// Release gate before driving the shared pins
						s_d.oe_n = 1'b1;
						s_d.rmw  = 1'b0;
						s_d.cnt  = '0;
						s_d.st   = dram_ctl_pkg::ST_HOLD;
					end else begin
						s_d.cnt = '0;
						s_d.st  = dram_ctl_pkg::ST_PRECHG;
						s_d.page = s_q.page;
						s_d.ras_n = !s_q.page;
						s_d.cas_n = 1'b1;
						s_d.we_n  = 1'b1;
						s_d.oe_n  = 1'b1;
						s_d.doe   = 1'b0;
						s_d.test  = 1'b0;
						// Page mode keeps the row open
						if (s_q.page) begin
							s_d.st    = dram_ctl_pkg::ST_HOLD;
							s_d.ready = 1'b1;
						end
					end
				end
			end
			dram_ctl_pkg::ST_HOLD: begin
				if (!s_q.cas_n) begin
					// Read-modify-write store phase
					if (expired(s_q.cnt, dram_ctl_pkg::OEZ_CYC)) begin
						s_d.dout = s_q.wdata;
						s_d.doe  = 1'b1;
						s_d.we_n = 1'b0;
						// Stays a write so the store phase sends no second response
						s_d.write = 1'b1;
						s_d.cnt  = '0;
						s_d.st   = dram_ctl_pkg::ST_COL;
					end
				end else if (expired(s_q.cnt, dram_ctl_pkg::CPN_CYC)) begin
					// Open page: next column in the same row; a same-row counter test waits, else close
					if (req_valid && req_addr[17:9] == s_q.row && !req_cbr_test && !ref_req) begin
						s_d.col   = req_addr[8:0];
						s_d.addr  = req_addr[8:0];
						s_d.write = req_write;
						s_d.rmw   = req_rmw;
						s_d.page  = req_page;
						s_d.wdata = req_wdata;
						s_d.ready = 1'b0;
						s_d.st    = dram_ctl_pkg::ST_PAGE_PRE;
					end else if (!req_valid || ref_req || req_addr[17:9] != s_q.row) begin
						s_d.ras_n = 1'b1;
						s_d.ready = 1'b0;
						s_d.cnt   = '0;
						s_d.st    = dram_ctl_pkg::ST_PRECHG;
					end
				end
			end
			dram_ctl_pkg::ST_PRECHG: begin
				// Both strobes high; new cycle only after precharge
				s_d.ras_n = 1'b1;
				s_d.cas_n = 1'b1;
				s_d.doe   = 1'b0;
				if (expired(s_q.cnt, dram_ctl_pkg::RP_CYC)) begin
					s_d.cnt = '0;
					if (!s_q.done && s_q.inits != 4'(dram_ctl_pkg::INIT_CYCLES)) begin
						// Initialization: row strobe cycles
						s_d.inits = s_q.inits + 4'h1;
						s_d.cas_n = 1'b0;
						s_d.st    = dram_ctl_pkg::ST_CBR_SET;
					end else begin
						s_d.done  = 1'b1;
						s_d.ready = 1'b1;
						s_d.st    = dram_ctl_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				s_d.st = dram_ctl_pkg::ST_PRECHG;
			end
		endcase
		s_d.ready = s_d.ready && (s_d.st == dram_ctl_pkg::ST_IDLE
			|| s_d.st == dram_ctl_pkg::ST_HOLD);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q       <= '0;
			s_q.st    <= dram_ctl_pkg::ST_POWERUP;
			s_q.ras_n <= 1'b1;
			s_q.cas_n <= 1'b1;
			s_q.we_n  <= 1'b1;
			s_q.oe_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign row_strobe_n        = s_q.ras_n;
	assign column_strobe_n     = s_q.cas_n;
	assign write_select_n      = s_q.we_n;
	assign output_gate_n       = s_q.oe_n;
	assign multiplexed_address = s_q.addr;
	assign data_out            = s_q.dout;
	assign data_oe             = s_q.doe;
	assign req_ready           = s_q.ready;
	assign rsp_valid           = s_q.rvalid;
	assign rsp_rdata           = s_q.rdata;
	assign init_done           = s_q.done;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_strobes_powerup: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.st == dram_ctl_pkg::ST_POWERUP |-> row_strobe_n && column_strobe_n)
		else $error("strobe low during power-up");
	a_precharge_min: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(row_strobe_n) |-> row_strobe_n [*8])
		else $error("row precharge too short");
	a_row_pulse_min: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(row_strobe_n) |-> !row_strobe_n [*3])
		else $error("row strobe pulse too short");
	a_no_bus_fight: assert property (@(posedge ref_clk) disable iff (rst)
		data_oe |-> output_gate_n)
		else $error("driving pins while gate low");
	a_early_write: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(column_strobe_n) && data_oe |-> !write_select_n)
		else $error("write data without early write-select");
	a_col_after_row: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(column_strobe_n) && !$past(row_strobe_n) && !s_q.test |-> !row_strobe_n)
		else $error("column strobe fell with row high");
	a_read_resp: assert property (@(posedge ref_clk) disable iff (rst)
		rsp_valid |-> !output_gate_n || $past(!output_gate_n))
		else $error("read response without gate");
	a_cbr_setup: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(row_strobe_n) && $past(!column_strobe_n) |-> $past(!column_strobe_n, 2))
		else $error("refresh column setup short");
endmodule
`default_nettype wire

/* test/dram_model.sv */
// Behavioural model of the 256K x 4 DRAM as seen at the controller's pins.
// Assumes only the controller drives strobes; timing is checked in real time.
`timescale 1ns/1ps
`default_nettype none
module dram_model (
	input  wire logic       row_strobe_n,
	input  wire logic       column_strobe_n,
	input  wire logic       write_select_n,
	input  wire logic       output_gate_n,
	input  wire logic [8:0] multiplexed_address,
	input  wire logic [3:0] data_out,
	output logic      [3:0] data_in,
	output logic            driving,
	output var logic        timing_fault,
	output var logic        test_seen,
	output var int          row_cycles,
	output var int          cbr_count,
	output var real         first_fall
);
	logic [3:0] mem [0:262143];
	logic [8:0] row_q;
	logic [8:0] col_q;
	logic [8:0] refresh_row_q;
	logic [3:0] rd_q;
	logic       read_mode;
	logic       cbr_active;
	logic       col_high_seen;
	realtime    t_rf;
	realtime    t_rr;
	realtime    t_cf;

	initial begin
		timing_fault = 1'b0;
		test_seen = 1'b0;
		row_cycles = 0;
		cbr_count = 0;
		first_fall = 0.0;
		refresh_row_q = 9'h000;
		rd_q = 4'h0;
		read_mode = 1'b0;
		cbr_active = 1'b0;
		col_high_seen = 1'b0;
		t_rf = -1000.0;
		t_rr = -1000.0;
		t_cf = -1000.0;
	end

	always @(negedge row_strobe_n) begin
		if ($realtime - t_rr < 80.0) timing_fault = 1'b1;
		if (row_cycles == 0) first_fall = $realtime;
		row_cycles++;
		t_rf = $realtime;
		col_high_seen = 1'b0;
		cbr_active = (column_strobe_n === 1'b0);
		if (cbr_active) begin
			cbr_count++;
			refresh_row_q = refresh_row_q + 9'h001;
		end else begin
			row_q = multiplexed_address;
		end
	end

	always @(posedge row_strobe_n) begin
		if ($realtime - t_rf < 100.0) timing_fault = 1'b1;
		t_rr = $realtime;
	end

	always @(posedge column_strobe_n) begin
		if ($realtime - t_cf < 25.0) timing_fault = 1'b1;
		if (row_strobe_n === 1'b0 && cbr_active) col_high_seen = 1'b1;
		read_mode = 1'b0;
	end

	// A plain column fall in a counter-before-row cycle carries no access
	always @(negedge column_strobe_n) begin
		t_cf = $realtime;
		if (row_strobe_n === 1'b0 && (!cbr_active || col_high_seen)) begin
			if (cbr_active) begin
				test_seen = 1'b1;
				row_q = refresh_row_q;
			end
			col_q = multiplexed_address;
			read_mode = write_select_n;
			if (write_select_n === 1'b0) mem[{row_q, col_q}] = data_out;
			rd_q = mem[{row_q, col_q}];
		end
	end

	always @(negedge write_select_n) begin
		if (column_strobe_n === 1'b0 && read_mode) mem[{row_q, col_q}] = data_out;
	end

	// Released pins show the inverse of the last word, never a stale match
	assign driving = !column_strobe_n && !output_gate_n && read_mode;
	assign data_in = driving ? rd_q : ~rd_q;
endmodule
`default_nettype wire

/* test/tb_async_dram_256kx4_core.sv */
// Self-checking bench for the DRAM controller against a behavioural DRAM.
// Assumes shortened power-up and refresh counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module tb_async_dram_256kx4_core;
	localparam int POWERUP  = 50;
	localparam int INTERVAL = 200;
	localparam int CEILING  = 20000;
	logic        ref_clk, rst, req_valid, req_write, req_rmw, req_page, req_cbr_test;
	logic [17:0] req_addr;
	logic [3:0]  req_wdata, rsp_rdata, data_in, data_out, q;
	logic        req_ready, rsp_valid, init_done, row_strobe_n, column_strobe_n;
	logic        write_select_n, output_gate_n, data_oe, driving, timing_fault, test_seen;
	logic [8:0]  multiplexed_address;
	int          row_cycles, cbr_count, n_mismatch, comparisons, cycles, c0;
	real         first_fall;

	dram_ctl #(.POWERUP_CYCLES(POWERUP), .REFRESH_INTERVAL(INTERVAL)) dut (
		.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
		.req_rmw(req_rmw), .req_page(req_page), .req_cbr_test(req_cbr_test),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.write_select_n(write_select_n), .output_gate_n(output_gate_n),
		.multiplexed_address(multiplexed_address), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe));

	dram_model model (
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.write_select_n(write_select_n), .output_gate_n(output_gate_n),
		.multiplexed_address(multiplexed_address), .data_out(data_out),
		.data_in(data_in), .driving(driving), .timing_fault(timing_fault),
		.test_seen(test_seen), .row_cycles(row_cycles), .cbr_count(cbr_count),
		.first_fall(first_fall));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Fields held until an edge where ready is high and the request is taken; reads wait for rsp
	task automatic access(input logic w, rmw, page, cbr, input logic [17:0] a,
		input logic [3:0] d);
		int n;
		logic taken;
		logic was_ready;
		n = 0;
		taken = 1'b0;
		req_valid = 1'b1;
		req_write = w;
		req_rmw = rmw;
		req_page = page;
		req_cbr_test = cbr;
		req_addr = a;
		req_wdata = d;
		// A refresh may preempt a ready edge, so hold until really taken
		while (!taken && n < 3000) begin
			was_ready = (req_ready === 1'b1);
			@(posedge ref_clk);
			#1;
			n++;
			taken = was_ready && (dut.s_q.st == dram_ctl_pkg::ST_ROW
				|| dut.s_q.st == dram_ctl_pkg::ST_PAGE_PRE
				|| (dut.s_q.st == dram_ctl_pkg::ST_CBR_SET && !dut.s_q.refresh));
		end
		req_valid = 1'b0;
		check("request taken", 1, taken);
		q = 4'h0;
		for (n = 0; n < 200 && (!w || rmw) && rsp_valid !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if ((!w || rmw) && rsp_valid !== 1'b1) check("read response", 1, rsp_valid);
		if (!w || rmw) q = rsp_rdata;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_powerup;
		for (int n = 0; n < 3000 && init_done !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		check("init_done", 1, init_done);
		check("init row cycles", 8, row_cycles);
		check("power-up wait", 1, first_fall >= (POWERUP + 3) * 10.0);
	endtask

	task automatic sc_write_read;
		logic [17:0] addrs [3] = '{18'h3_ffff, 18'h0_0000, 18'h1_5a5a};
		logic [3:0]  words [3] = '{4'h9, 4'h6, 4'h5};
		for (int i = 0; i < 3; i++) access(1, 0, 0, 0, addrs[i], words[i]);
		for (int i = 0; i < 3; i++) begin
			access(0, 0, 0, 0, addrs[i], 4'h0);
			check("read word", words[i], q);
		end
	endtask

	task automatic sc_rmw;
		access(1, 1, 0, 0, 18'h1_5a5a, 4'ha);
		check("rmw old word", 4'h5, q);
		access(0, 0, 0, 0, 18'h1_5a5a, 4'h0);
		check("rmw new word", 4'ha, q);
	endtask

	task automatic sc_refresh;
		c0 = cbr_count;
		repeat (3 * INTERVAL + 20) @(posedge ref_clk);
		#1;
		check("refresh count", 1, cbr_count - c0 >= 3 && cbr_count - c0 <= 4);
		access(0, 0, 0, 0, 18'h3_ffff, 4'h0);
		check("word after refresh", 4'h9, q);
	endtask

	task automatic sc_page;
		access(1, 0, 0, 0, 18'h1_4601, 4'h3);
		access(1, 0, 0, 0, 18'h1_4602, 4'hd);
		c0 = cbr_count;
		for (int n = 0; n < INTERVAL + 50 && cbr_count == c0; n++) begin
			@(posedge ref_clk);
			#1;
		end
		c0 = row_cycles;
		access(0, 0, 1, 0, 18'h1_4601, 4'h0);
		check("page word 1", 4'h3, q);
		access(0, 0, 0, 0, 18'h1_4602, 4'h0);
		check("page word 2", 4'hd, q);
		check("page row cycles", 1, row_cycles - c0);
	endtask

	task automatic sc_counter_test;
		c0 = cbr_count;
		access(0, 0, 0, 1, 18'h0_0010, 4'h0);
		check("counter test seen", 1, test_seen);
		check("counter test refresh", 1, cbr_count - c0 >= 1);
	endtask

	// ------------------------------------------------------------
	// Main sequence, contention watch and timeout
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (driving === 1'b1 && data_oe === 1'b1) begin
			n_mismatch++;
			$display("unexpected data pin contention: expected 0, seen 1");
		end
		if (cycles >= CEILING) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_rmw = 1'b0;
		req_page = 1'b0;
		req_cbr_test = 1'b0;
		req_addr = 18'h0_0000;
		req_wdata = 4'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		check("row strobe in reset", 1, row_strobe_n);
		check("column strobe in reset", 1, column_strobe_n);
		rst = 1'b0;
		sc_powerup;
		sc_write_read;
		sc_rmw;
		sc_refresh;
		sc_page;
		sc_counter_test;
		check("strobe timing faults", 0, timing_fault);
		report_and_stop;
	end
endmodule
`default_nettype wire
